// ===== bq_cfg.svh
// constants of the burst-of-two separate-io sram link
`ifndef BQ_CFG_SVH
`define BQ_CFG_SVH
`define BQ_DATA_W      36
`define BQ_NARROW_W    18
`define BQ_WORD_W      72
`define BQ_ADDR_W      23
`define BQ_ENTRIES     16
`define BQ_IDX_W       4
`define BQ_CNT_W       2
`define BQ_PH_ACCEPT   2'h1
`define BQ_PH_LAUNCH   2'h2
`define BQ_PH_SAMPLE   2'h3
`define BQ_PH_HIGH_MAX 2'h1
`define BQ_STRAP_SPLIT 1'h1
`define BQ_STRAP_BURST 1'h0
`define BQ_RD_STAGES   2
`endif

// ===== bq_link_assertions.sv
// checker of the link between memory controller and sram device
`timescale 1ns/1ps
`default_nettype none
module bq_link_assertions (
  input wire logic             master_timing_input, // link clock
  input wire logic             rst_b_i,             // async reset, active low
  input wire logic             rd_en,               // read command
  input wire logic             wr_en,               // write command
  input wire bq_pkg::bq_addr_t addr_input_rd,       // read address
  input wire bq_pkg::bq_addr_t addr_input_wr,       // write address
  input wire logic             write_data_strobe,   // write beat qualifier
  input wire logic             io_split_strap,      // split io strap
  input wire logic             burst_length_strap,  // burst length strap
  input wire logic             read_valid_flag      // read beat valid
);
  default clocking cb @(posedge master_timing_input);
  endclocking
  default disable iff (!rst_b_i);

  // two consecutive beats of a burst
  sequence rd_beats;
    read_valid_flag [*2];
  endsequence
  sequence wr_beats;
    write_data_strobe [*2];
  endsequence

  // read data window tied to the command
  rd_lat_a: assert property (rd_en |-> ##4 rd_beats)
    else $error("read beats not at fixed latency");
  rd_end_a: assert property (rd_en ##2 !rd_en |-> ##4 !read_valid_flag)
    else $error("read valid longer than two beats");
  flag_cause_a: assert property ($rose(read_valid_flag) |-> $past(rd_en, 4))
    else $error("read valid without read command");
  // write side framing, then spacing of read and write commands
  wr_strobe_a: assert property (wr_en |-> wr_beats)
    else $error("write strobe not on both beats");
  strobe_cause_a: assert property ($rose(write_data_strobe) |-> wr_en)
    else $error("write strobe without write command");
  rd_space_a: assert property (rd_en |=> !rd_en)
    else $error("read commands too close");
  wr_space_a: assert property (wr_en |=> !wr_en)
    else $error("write commands too close");
  // addresses held past their capture edge, then straps checked on every command
  rd_addr_hold_a: assert property (rd_en |=> $stable(addr_input_rd))
    else $error("read address moved after command");
  wr_addr_hold_a: assert property (wr_en |=> $stable(addr_input_wr))
    else $error("write address moved after command");
  strap_ok_a: assert property ((rd_en || wr_en) |-> io_split_strap && !burst_length_strap)
    else $error("command issued with wrong straps");
endmodule : bq_link_assertions
`default_nettype wire

// ===== bq_link_if.sv
// link wires between memory controller and sram device
`timescale 1ns/1ps
`default_nettype none
interface bq_link_if;
  logic             master_timing_input;
  logic             rd_en;
  logic             wr_en;
  bq_pkg::bq_addr_t addr_input_rd;
  bq_pkg::bq_addr_t addr_input_wr;
  bq_pkg::bq_beat_t wdata;
  logic             write_data_strobe;
  logic             width_strap;
  logic             io_split_strap;
  logic             burst_length_strap;
  bq_pkg::bq_beat_t rdata;
  logic             read_valid_flag;

  modport dev (
    input  master_timing_input, rd_en, wr_en, addr_input_rd, addr_input_wr, wdata,
    input  write_data_strobe, width_strap, io_split_strap, burst_length_strap,
    output rdata, read_valid_flag
  );
  modport ctl (
    output master_timing_input, rd_en, wr_en, addr_input_rd, addr_input_wr, wdata,
    output write_data_strobe, width_strap, io_split_strap, burst_length_strap,
    input  rdata, read_valid_flag
  );
endinterface : bq_link_if
`default_nettype wire

// ===== bq_pkg.sv
// shared types of the burst-of-two sram link
`include "bq_cfg.svh"
package bq_pkg;
  typedef logic [`BQ_DATA_W-1:0] bq_beat_t;
  typedef logic [`BQ_WORD_W-1:0] bq_word_t;
  typedef logic [`BQ_ADDR_W-1:0] bq_addr_t;
  typedef logic [`BQ_IDX_W-1:0]  bq_idx_t;

  // device state, link clock domain
  typedef struct packed {
    logic [2:0]                  strap_s1;
    logic [2:0]                  strap_s2;
    logic                        wr_hi_due;
    bq_idx_t                     wr_idx;
    bq_beat_t                    wr_lo;
    logic [`BQ_RD_STAGES-1:0]    rd_stage;
    bq_idx_t                     rd_idx1;
    bq_idx_t                     rd_idx2;
    logic                        out_due;
    logic                        hi_due;
    bq_word_t                    out_word;
    bq_beat_t                    dout;
    logic                        dvalid;
    bq_word_t [`BQ_ENTRIES-1:0]  mem;
  } bq_dev_state_t;

  // controller state, reference clock domain
  typedef struct packed {
    logic [`BQ_CNT_W-1:0] cnt;
    logic                 link_clk;
    logic                 rd_en;
    logic                 wr_en;
    bq_addr_t             rd_addr;
    bq_addr_t             wr_addr;
    bq_beat_t             wdata;
    logic                 wstrobe;
    logic                 beat2_due;
    logic                 beat2_wr;
    bq_beat_t             wr_hi;
    logic                 launch_due;
    logic                 launch_rd;
    logic                 launch_wr;
    bq_word_t             wr_word;
    logic [`BQ_DATA_W:0]  rsync1;
    logic [`BQ_DATA_W:0]  rsync2;
    logic                 have_lo;
    bq_beat_t             rd_lo;
    bq_word_t             rd_data;
    logic                 rd_valid;
  } bq_ctl_state_t;
endpackage : bq_pkg

// ===== bq_sram_ctl.sv
// memory controller end: clock divider, command launch, read reassembly
`timescale 1ns/1ps
`default_nettype none
`include "bq_cfg.svh"
module bq_sram_ctl (
  input  wire logic             ref_clk_i,    // controller clock
  input  wire logic             rst_b_i,      // async reset, active low
  input  wire logic             width_x18_i,  // select 18-bit organisation
  input  wire logic             rd_req_i,     // read request
  input  wire bq_pkg::bq_addr_t rd_addr_i,    // read address
  input  wire logic             wr_req_i,     // write request
  input  wire bq_pkg::bq_addr_t wr_addr_i,    // write address
  input  wire bq_pkg::bq_word_t wr_data_i,    // write word, low beat in low half
  output logic                  req_ready_o,  // requests taken this cycle
  output bq_pkg::bq_word_t      rd_data_o,    // reassembled read word
  output logic                  rd_valid_o,   // read word valid pulse
  bq_link_if.ctl                link          // link to the device
);
  bq_pkg::bq_ctl_state_t st_reg;
  bq_pkg::bq_ctl_state_t st_next;

  // one request slot per link cycle, none while a second beat is due
  assign req_ready_o = (st_reg.cnt == `BQ_PH_ACCEPT) && !st_reg.beat2_due && !st_reg.launch_due;

  always_comb begin
    st_next          = st_reg;
    st_next.rd_valid = 1'h0;
    st_next.cnt      = st_reg.cnt + `BQ_CNT_W'(1);
    // link clock high in the first half of each period
    st_next.link_clk = (st_next.cnt <= `BQ_PH_HIGH_MAX);
    // take a request; read and write may come together
    if (req_ready_o && (rd_req_i || wr_req_i)) begin
      st_next.launch_due = 1'h1;
      st_next.launch_rd  = rd_req_i;
      st_next.launch_wr  = wr_req_i;
      st_next.rd_addr    = rd_addr_i;
      st_next.wr_addr    = wr_addr_i;
      st_next.wr_word    = wr_data_i;
    end
    // drive link one ref cycle after the falling edge so the device sees it settled
    if (st_reg.cnt == `BQ_PH_LAUNCH) begin
      st_next.rd_en   = 1'h0;
      st_next.wr_en   = 1'h0;
      st_next.wstrobe = 1'h0;
      if (st_reg.launch_due) begin
        st_next.launch_due = 1'h0;
        st_next.rd_en      = st_reg.launch_rd;
        st_next.wr_en      = st_reg.launch_wr;
        st_next.wdata      = st_reg.wr_word[`BQ_DATA_W-1:0];
        st_next.wstrobe    = st_reg.launch_wr;
        st_next.wr_hi      = st_reg.wr_word[`BQ_WORD_W-1:`BQ_DATA_W];
        st_next.beat2_due  = 1'h1;
        st_next.beat2_wr   = st_reg.launch_wr;
      end else if (st_reg.beat2_due) begin
        // second beat of the burst
        st_next.beat2_due = 1'h0;
        st_next.wdata     = st_reg.wr_hi;
        st_next.wstrobe   = st_reg.beat2_wr;
      end
    end
    // read data from the link domain, two flops deep
    st_next.rsync1 = {link.read_valid_flag, link.rdata};
    st_next.rsync2 = st_reg.rsync1;
    // pair the two read beats, low first
    if ((st_reg.cnt == `BQ_PH_SAMPLE) && st_reg.rsync2[`BQ_DATA_W]) begin
      if (!st_reg.have_lo) begin
        st_next.have_lo = 1'h1;
        st_next.rd_lo   = st_reg.rsync2[`BQ_DATA_W-1:0];
      end else begin
        st_next.have_lo  = 1'h0;
        st_next.rd_data  = {st_reg.rsync2[`BQ_DATA_W-1:0], st_reg.rd_lo};
        st_next.rd_valid = 1'h1;
      end
    end else if ((st_reg.cnt == `BQ_PH_SAMPLE) && st_reg.have_lo) begin
      st_next.have_lo = 1'h0;  // lone beat dropped
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // link clock made here by division
  assign link.master_timing_input = st_reg.link_clk;
  assign link.rd_en               = st_reg.rd_en;
  assign link.wr_en               = st_reg.wr_en;
  assign link.addr_input_rd       = st_reg.rd_addr;
  assign link.addr_input_wr       = st_reg.wr_addr;
  assign link.wdata               = st_reg.wdata;
  assign link.write_data_strobe   = st_reg.wstrobe;
  // straps
  assign link.width_strap         = width_x18_i;
  assign link.io_split_strap      = `BQ_STRAP_SPLIT;
  assign link.burst_length_strap  = `BQ_STRAP_BURST;
  assign rd_data_o                = st_reg.rd_data;
  assign rd_valid_o               = st_reg.rd_valid;
endmodule : bq_sram_ctl
`default_nettype wire

// ===== bq_sram_dev.sv
// sram device end: command capture, write demux, array, read mux
`timescale 1ns/1ps
`default_nettype none
`include "bq_cfg.svh"
module bq_sram_dev (
  input  wire logic rst_b_i,       // async reset, active low
  output logic      cfg_ok_o,      // straps select a supported mode
  output logic      narrow_o,      // 18-bit organisation active
  output logic      rd_busy_o,     // a read burst is in flight
  bq_link_if.dev    link           // link to the controller
);
  bq_pkg::bq_dev_state_t st_reg;
  bq_pkg::bq_dev_state_t st_next;

  // strap decode from the second sync flop only
  logic strap_x18;
  logic strap_ok;
  assign strap_x18 = st_reg.strap_s2[2];
  assign strap_ok  = (st_reg.strap_s2[1] == `BQ_STRAP_SPLIT)
                  && (st_reg.strap_s2[0] == `BQ_STRAP_BURST);

  // array index from the low four address bits only; the top address bit is never used
  function automatic bq_pkg::bq_idx_t idx_of(input bq_pkg::bq_addr_t a);
    idx_of = a[`BQ_IDX_W-1:0];
  endfunction : idx_of

  // keep only the live data lanes for the selected organisation
  function automatic bq_pkg::bq_beat_t lane_mask(input bq_pkg::bq_beat_t b, input logic x18);
    bq_pkg::bq_beat_t m;
    m = b;
    if (x18) begin
      m[`BQ_DATA_W-1:`BQ_NARROW_W] = '0;
    end
    lane_mask = m;
  endfunction : lane_mask

  logic take_rd;
  logic take_wr;

  // commands honoured only with supported straps; a new one waits out a burst
  assign take_rd = link.rd_en && strap_ok && !st_reg.rd_stage[0];
  assign take_wr = link.wr_en && link.write_data_strobe && strap_ok && !st_reg.wr_hi_due;

  always_comb begin
    st_next          = st_reg;
    st_next.strap_s1 = {link.width_strap, link.io_split_strap, link.burst_length_strap};
    st_next.strap_s2 = st_reg.strap_s1;

    // write side: first beat and address on the rising edge
    st_next.wr_hi_due = 1'h0;
    if (take_wr) begin
      st_next.wr_hi_due = 1'h1;
      st_next.wr_idx    = idx_of(link.addr_input_wr);
      st_next.wr_lo     = lane_mask(link.wdata, strap_x18);
    end
    // second beat completes the word; both halves written at once
    if (st_reg.wr_hi_due && link.write_data_strobe) begin
      st_next.mem[st_reg.wr_idx] = {lane_mask(link.wdata, strap_x18), st_reg.wr_lo};
    end

    // read side: address taken in the same edge as a write
    st_next.rd_stage = {st_reg.rd_stage[0], take_rd};
    if (take_rd) begin
      st_next.rd_idx1 = idx_of(link.addr_input_rd);
    end
    st_next.rd_idx2 = st_reg.rd_idx1;

    // one array read caught whole in the output mux
    st_next.out_due = st_reg.rd_stage[1];
    if (st_reg.rd_stage[1]) begin
      st_next.out_word = st_reg.mem[st_reg.rd_idx2];
    end

    // beats out on consecutive edges, low half first
    st_next.dvalid = 1'h0;
    st_next.hi_due = 1'h0;
    if (st_reg.out_due) begin
      st_next.dout   = st_reg.out_word[`BQ_DATA_W-1:0];
      st_next.dvalid = 1'h1;
      st_next.hi_due = 1'h1;
    end else if (st_reg.hi_due) begin
      st_next.dout   = st_reg.out_word[`BQ_WORD_W-1:`BQ_DATA_W];
      st_next.dvalid = 1'h1;
    end
  end

  // all device state on the master clock edge
  always_ff @(posedge link.master_timing_input or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // output bus is separate from the input bus
  assign link.rdata           = st_reg.dout;
  assign link.read_valid_flag = st_reg.dvalid;
  assign cfg_ok_o             = strap_ok;
  assign narrow_o             = strap_x18;
  assign rd_busy_o            = |{st_reg.rd_stage, st_reg.out_due, st_reg.hi_due};
endmodule : bq_sram_dev
`default_nettype wire

// ===== burst2_qdr_sram_interface_tb.sv
// self-checking bench of controller and device joined by the link
`timescale 1ns/1ps
`default_nettype none
module burst2_qdr_sram_interface_tb;
  logic             ref_clk_i, rst_b_i, width_x18_i, rd_req_i, wr_req_i;
  logic             req_ready_o, rd_valid_o, cfg_ok_o, narrow_o, cfg2_ok, rd_busy;
  bq_pkg::bq_addr_t rd_addr_i, wr_addr_i;
  bq_pkg::bq_word_t wr_data_i, rd_data_o;
  int               n_errors, check_count, cyc;
  bq_link_if lnk();
  bq_link_if lnk2();

  bq_sram_ctl u_bq_sram_ctl (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .width_x18_i(width_x18_i),
    .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .wr_req_i(wr_req_i), .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i), .req_ready_o(req_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .link(lnk.ctl));
  bq_sram_dev u_bq_sram_dev (.rst_b_i(rst_b_i), .cfg_ok_o(cfg_ok_o), .narrow_o(narrow_o),
    .rd_busy_o(rd_busy), .link(lnk.dev));
  // second device, driven by the bench with good straps, then a low split strap, then a high burst strap
  bq_sram_dev u_bq_sram_dev_b (.rst_b_i(rst_b_i), .cfg_ok_o(cfg2_ok), .narrow_o(), .rd_busy_o(),
    .link(lnk2.dev));
  bq_link_assertions u_bq_link_assertions (.master_timing_input(lnk.master_timing_input),
    .rst_b_i(rst_b_i), .rd_en(lnk.rd_en), .wr_en(lnk.wr_en), .addr_input_rd(lnk.addr_input_rd),
    .addr_input_wr(lnk.addr_input_wr), .write_data_strobe(lnk.write_data_strobe),
    .io_split_strap(lnk.io_split_strap), .burst_length_strap(lnk.burst_length_strap),
    .read_valid_flag(lnk.read_valid_flag));

  always #12.5 ref_clk_i = ~ref_clk_i;
  // hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input bq_pkg::bq_word_t seen, input bq_pkg::bq_word_t exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // request held until a ready cycle takes it
  task automatic req(input logic r, input logic w, input bq_pkg::bq_addr_t ra, input bq_pkg::bq_addr_t wa,
                     input bq_pkg::bq_word_t wd);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    rd_req_i <= r;
    wr_req_i <= w;
    rd_addr_i <= ra;
    wr_addr_i <= wa;
    wr_data_i <= wd;
    @(negedge ref_clk_i);
    while (req_ready_o !== 1'b1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    rd_req_i <= 1'b0;
    wr_req_i <= 1'b0;
  endtask : req

  // waits for the read word, first link beat noted on the way
  task automatic get(input bq_pkg::bq_word_t exp);
    int n;
    logic got;
    logic bz;
    bq_pkg::bq_beat_t b0;
    n = 0;
    got = 1'b0;
    bz = 1'b0;
    b0 = '0;
    @(negedge ref_clk_i);
    while (rd_valid_o !== 1'b1 && n < 60) begin
      if (lnk.read_valid_flag === 1'b1 && !got) begin
        b0 = lnk.rdata;
        bz = rd_busy;
        got = 1'b1;
      end
      @(negedge ref_clk_i);
      n++;
    end
    chk(rd_data_o, exp);
    chk(72'(b0), 72'(exp[35:0]));
    chk(72'(bz), 72'h1);
    chk(72'(rd_busy), 72'h0);
  endtask : get

  task automatic t_reset();
    repeat (15) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(72'(req_ready_o), 72'h0);
    chk(72'(lnk.master_timing_input), 72'h0);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (40) @(negedge ref_clk_i);
    chk(72'(cfg_ok_o), 72'h1);
    chk(72'(narrow_o), 72'h0);
    chk(72'(lnk.io_split_strap), 72'h1);
    chk(72'(lnk.burst_length_strap), 72'h0);
    $display("test reset done");
  endtask : t_reset

  // back-to-back writes, then reads of both words
  task automatic t_rw();
    req(1'b0, 1'b1, '0, 23'h40_0005, 72'h11_2222_3333_4444_5555);
    req(1'b0, 1'b1, '0, 23'h00_0006, 72'h66_7777_8888_9999_aaaa);
    req(1'b1, 1'b0, 23'h40_0005, '0, '0);
    get(72'h11_2222_3333_4444_5555);
    req(1'b1, 1'b0, 23'h00_0006, '0, '0);
    get(72'h66_7777_8888_9999_aaaa);
    $display("test write read done");
  endtask : t_rw

  // read and write taken in one cycle
  task automatic t_same();
    req(1'b1, 1'b1, 23'h00_0006, 23'h00_0009, 72'hbb_cccc_dddd_eeee_ffff);
    get(72'h66_7777_8888_9999_aaaa);
    req(1'b1, 1'b0, 23'h00_0009, '0, '0);
    get(72'hbb_cccc_dddd_eeee_ffff);
    $display("test same cycle done");
  endtask : t_same

  // narrow organisation keeps only 18 bits of each beat
  task automatic t_narrow();
    @(posedge ref_clk_i);
    width_x18_i <= 1'b1;
    repeat (40) @(negedge ref_clk_i);
    chk(72'(narrow_o), 72'h1);
    chk(72'(lnk.width_strap), 72'h1);
    req(1'b0, 1'b1, '0, 23'h00_0003, 72'hff_ffff_ffff_ffff_ffff);
    req(1'b1, 1'b0, 23'h00_0003, '0, '0);
    get({18'h0, 18'h3_ffff, 18'h0, 18'h3_ffff});
    @(posedge ref_clk_i);
    width_x18_i <= 1'b0;
    repeat (40) @(negedge ref_clk_i);
    $display("test narrow done");
  endtask : t_narrow

  // device b: good straps honour a read, a low split or high burst strap refuses it
  task automatic t_fault();
    int f;
    f = 0;
    for (int i = 0; i < 30; i++) begin
      lnk2.io_split_strap     = (i < 10) || (i >= 20);
      lnk2.burst_length_strap = (i >= 20);
      lnk2.rd_en              = (i % 10 == 4);
      #62.5 lnk2.master_timing_input = 1'b1;
      #62.5 lnk2.master_timing_input = 1'b0;
      if (lnk2.read_valid_flag === 1'b1) f++;
      if (i % 10 == 9) chk(72'(cfg2_ok), (i == 9) ? 72'h1 : 72'h0);
    end
    chk(72'(f), 72'h2);
    $display("test strap fault done");
  endtask : t_fault

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    {ref_clk_i, rst_b_i, width_x18_i, rd_req_i, wr_req_i} = '0;
    {rd_addr_i, wr_addr_i, wr_data_i} = '0;
    {n_errors, check_count, cyc} = '0;
    {lnk2.master_timing_input, lnk2.rd_en, lnk2.wr_en, lnk2.write_data_strobe} = '0;
    {lnk2.width_strap, lnk2.io_split_strap, lnk2.burst_length_strap} = '0;
    {lnk2.addr_input_rd, lnk2.addr_input_wr, lnk2.wdata} = '0;
    t_reset();
    t_rw();
    t_same();
    t_narrow();
    t_fault();
    conclude();
  end
endmodule : burst2_qdr_sram_interface_tb
`default_nettype wire
